// ---- core/sat_table_access.v ----
// Operation
// - sixteen static entries, chosen by a four-bit index in control
// - every destination lookup checks all tables; a static hit beats a dynamic one
// - static entries never age; only host commands and reset change them
// - static read returns indexed entry in all four window words
// - go/done bit clears itself when the command finishes
// - word1 bit 30 drops packet on source address match
// - word1 bit 29 drops packet on destination address match
// - word1 holds valid 31, priority 28:26, spanning group 2:0
// - word2 bit 31 lets forwarding bypass port state
// - word2 bit 30 adds filter group compare for multicast
// - word2 bits 6:0 form port mask, bit 0 is port 1
// - word3 filter group 22:16, mac 47:32; word4 mac 31:0
// - eight reserved multicast masks indexed by low three address bits
// - 48 addresses in eight groups; writing one updates its group
// - multicast read returns indexed mask in word2
// - multicast data word sits at word2 offset, mask only
`timescale 1ns/1ps
`default_nettype none
`include "sat_defines.vh"

module sat_table_access #(
  parameter ENTRIES = 16,
  parameter GROUPS = 8,
  parameter PORTS = 7
) (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire [15:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_wdata_in,
  output reg [31:0] reg_rdata_out,
  output reg reg_ack_out,
  input wire da_valid_in,
  input wire [47:0] da_in,
  input wire [6:0] da_fid_in,
  input wire dyn_hit_in,
  input wire [PORTS-1:0] dyn_mask_in,
  input wire sa_valid_in,
  input wire [47:0] sa_in,
  input wire [6:0] sa_fid_in,
  output reg fwd_valid_out,
  output reg fwd_hit_out,
  output reg fwd_static_out,
  output reg [PORTS-1:0] fwd_mask_out,
  output reg fwd_drop_out,
  output reg fwd_override_out,
  output reg [2:0] fwd_priority_out,
  output reg [2:0] fwd_span_out,
  output reg src_valid_out,
  output reg src_drop_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [2:0] mc_group;
    input [5:0] idx;
    begin
      mc_group = idx[`SAT_MC_GRP];
    end
  endfunction

  function mc_in_range;
    input [5:0] idx;
    begin
      mc_in_range = (idx < `SAT_MC_LIMIT);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [31:0] w1_q;
  reg [31:0] w2_q;
  reg [31:0] w3_q;
  reg [31:0] w4_q;
  reg [5:0] idx_q;
  reg tsel_q;
  reg act_q;
  reg go_q;
  reg [`SAT_EW-1:0] st_mem [0:ENTRIES-1];
  reg [PORTS-1:0] mc_mask [0:GROUPS-1];
  integer i;

  wire [`SAT_EW-1:0] win_entry;
  wire [`SAT_EW*ENTRIES-1:0] st_flat;
  wire da_hit;
  wire [3:0] da_idx;
  wire sa_hit;
  wire [3:0] sa_idx;
  wire [`SAT_EW-1:0] da_ent;
  wire [`SAT_EW-1:0] sa_ent;
  wire da_is_mc;
  wire [`SAT_EW-1:0] rd_ent;

  assign win_entry = {w1_q[`SAT_W1_VALID], w1_q[`SAT_W1_SDROP], w1_q[`SAT_W1_DDROP],
                      w1_q[`SAT_W1_PRI], w1_q[`SAT_W1_SPAN], w2_q[`SAT_W2_OVR],
                      w2_q[`SAT_W2_USEFID], w2_q[`SAT_W2_FWD], w3_q[`SAT_W3_FID],
                      w3_q[`SAT_W3_MACHI], w4_q};
  assign rd_ent = st_mem[idx_q[`SAT_CTL_SIDX]];

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1)
    begin : flat
      assign st_flat[g*`SAT_EW +: `SAT_EW] = st_mem[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // register writes and command execution
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      w1_q <= `SAT_ZERO32;
      w2_q <= `SAT_ZERO32;
      w3_q <= `SAT_ZERO32;
      w4_q <= `SAT_ZERO32;
      idx_q <= 6'h00;
      tsel_q <= `SAT_TSEL_STATIC;
      act_q <= `SAT_ACT_WRITE;
      go_q <= 1'b0;
      for (i = 0; i < ENTRIES; i = i + 1)
        st_mem[i] <= `SAT_E_RESET;
      for (i = 0; i < GROUPS; i = i + 1)
        mc_mask[i] <= `SAT_MASK_RESET;
    end
    else if (go_q)
    begin
      go_q <= 1'b0;
      if (tsel_q == `SAT_TSEL_STATIC)
      begin
        if (act_q == `SAT_ACT_WRITE)
          st_mem[idx_q[`SAT_CTL_SIDX]] <= win_entry;
        else
        begin
          w1_q <= {rd_ent[`SAT_E_VALID], rd_ent[`SAT_E_SDROP], rd_ent[`SAT_E_DDROP],
                   rd_ent[`SAT_E_PRI], 23'h000000, rd_ent[`SAT_E_SPAN]};
          w2_q <= {rd_ent[`SAT_E_OVR], rd_ent[`SAT_E_USEFID], 23'h000000,
                   rd_ent[`SAT_E_FWD]};
          w3_q <= {9'h000, rd_ent[`SAT_E_FID], rd_ent[`SAT_E_MACHI]};
          w4_q <= rd_ent[`SAT_E_MACLO];
        end
      end
      else
      begin
        if (act_q == `SAT_ACT_WRITE)
        begin
          if (mc_in_range(idx_q))
            mc_mask[mc_group(idx_q)] <= w2_q[`SAT_W2_FWD];
        end
        else if (mc_in_range(idx_q))
          w2_q <= {w2_q[`SAT_W2_HI], 23'h000000, mc_mask[mc_group(idx_q)]};
        else
          w2_q <= {w2_q[`SAT_W2_HI], 30'h00000000};
      end
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == `SAT_OFF_CTRL)
      begin
        idx_q <= reg_wdata_in[`SAT_CTL_IDX];
        tsel_q <= reg_wdata_in[`SAT_CTL_TSEL];
        act_q <= reg_wdata_in[`SAT_CTL_ACT];
        go_q <= reg_wdata_in[`SAT_CTL_GO];
      end
      else if (reg_addr_in == `SAT_OFF_W1)
        w1_q <= reg_wdata_in & `SAT_W1_MASK;
      else if (reg_addr_in == `SAT_OFF_W2)
        w2_q <= reg_wdata_in & `SAT_W2_MASK;
      else if (reg_addr_in == `SAT_OFF_W3)
        w3_q <= reg_wdata_in & `SAT_W3_MASK;
      else if (reg_addr_in == `SAT_OFF_W4)
        w4_q <= reg_wdata_in & `SAT_W4_MASK;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      reg_rdata_out <= `SAT_ZERO32;
      reg_ack_out <= 1'b0;
    end
    else
    begin
      reg_ack_out <= reg_rd_in | reg_wr_in;
      if (!reg_rd_in)
        reg_rdata_out <= `SAT_ZERO32;
      else if (reg_addr_in == `SAT_OFF_CTRL)
        reg_rdata_out <= {23'h000000, go_q, act_q, tsel_q, idx_q};
      else if (reg_addr_in == `SAT_OFF_W1)
        reg_rdata_out <= w1_q;
      else if (reg_addr_in == `SAT_OFF_W2)
        reg_rdata_out <= w2_q;
      else if (reg_addr_in == `SAT_OFF_W3)
        reg_rdata_out <= w3_q;
      else if (reg_addr_in == `SAT_OFF_W4)
        reg_rdata_out <= w4_q;
      else
        reg_rdata_out <= `SAT_ZERO32;
    end
  end

  // ----------------------------------------------------------------
  // static table search
  // ----------------------------------------------------------------
  sat_match #(
    .ENTRIES(ENTRIES),
    .IDX_W(4)
  ) u_da_match (
    .entries_in(st_flat),
    .addr_in(da_in),
    .fid_in(da_fid_in),
    .hit_out(da_hit),
    .idx_out(da_idx)
  );

  sat_match #(
    .ENTRIES(ENTRIES),
    .IDX_W(4)
  ) u_sa_match (
    .entries_in(st_flat),
    .addr_in(sa_in),
    .fid_in(sa_fid_in),
    .hit_out(sa_hit),
    .idx_out(sa_idx)
  );

  assign da_ent = st_mem[da_idx];
  assign sa_ent = st_mem[sa_idx];
  assign da_is_mc = (da_in[`SAT_MC_PFX] == `SAT_MC_PREFIX) && mc_in_range(da_in[`SAT_MC_IDX]) &&
                    (da_in[`SAT_MC_TOP] == 2'b00);

  // ----------------------------------------------------------------
  // forwarding decision
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      fwd_valid_out <= 1'b0;
      fwd_hit_out <= 1'b0;
      fwd_static_out <= 1'b0;
      fwd_mask_out <= {PORTS{1'b0}};
      fwd_drop_out <= 1'b0;
      fwd_override_out <= 1'b0;
      fwd_priority_out <= 3'h0;
      fwd_span_out <= 3'h0;
      src_valid_out <= 1'b0;
      src_drop_out <= 1'b0;
    end
    else
    begin
      fwd_valid_out <= da_valid_in;
      src_valid_out <= sa_valid_in;
      src_drop_out <= sa_valid_in & sa_hit & sa_ent[`SAT_E_SDROP];
      if (da_valid_in && da_hit)
      begin
        fwd_hit_out <= 1'b1;
        fwd_static_out <= 1'b1;
        fwd_mask_out <= da_ent[`SAT_E_FWD];
        fwd_drop_out <= da_ent[`SAT_E_DDROP];
        fwd_override_out <= da_ent[`SAT_E_OVR];
        fwd_priority_out <= da_ent[`SAT_E_PRI];
        fwd_span_out <= da_ent[`SAT_E_SPAN];
      end
      else if (da_valid_in && da_is_mc)
      begin
        fwd_hit_out <= 1'b1;
        fwd_static_out <= 1'b1;
        fwd_mask_out <= mc_mask[mc_group(da_in[`SAT_MC_IDX])];
        fwd_drop_out <= 1'b0;
        fwd_override_out <= 1'b0;
        fwd_priority_out <= 3'h0;
        fwd_span_out <= 3'h0;
      end
      else
      begin
        fwd_hit_out <= da_valid_in & dyn_hit_in;
        fwd_static_out <= 1'b0;
        fwd_mask_out <= (da_valid_in & dyn_hit_in) ? dyn_mask_in : {PORTS{1'b0}};
        fwd_drop_out <= 1'b0;
        fwd_override_out <= 1'b0;
        fwd_priority_out <= 3'h0;
        fwd_span_out <= 3'h0;
      end
    end
  end

endmodule // sat_table_access

`default_nettype wire

// ---- core/sat_defines.vh ----
`ifndef SAT_DEFINES_VH
`define SAT_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SAT_OFF_CTRL 16'h041C
`define SAT_OFF_W1 16'h0420
`define SAT_OFF_W2 16'h0424
`define SAT_OFF_W3 16'h0428
`define SAT_OFF_W4 16'h042C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SAT_CTL_IDX 5:0
`define SAT_CTL_SIDX 3:0
`define SAT_CTL_TSEL 6
`define SAT_CTL_ACT 7
`define SAT_CTL_GO 8
`define SAT_TSEL_STATIC 1'b0
`define SAT_TSEL_MCAST 1'b1
`define SAT_ACT_WRITE 1'b0
`define SAT_ACT_READ 1'b1

// ----------------------------------------------------------------
// data window fields and write masks
// ----------------------------------------------------------------
`define SAT_W1_VALID 31
`define SAT_W1_SDROP 30
`define SAT_W1_DDROP 29
`define SAT_W1_PRI 28:26
`define SAT_W1_SPAN 2:0
`define SAT_W2_OVR 31
`define SAT_W2_USEFID 30
`define SAT_W2_HI 31:30
`define SAT_W2_FWD 6:0
`define SAT_W3_FID 22:16
`define SAT_W3_MACHI 15:0
`define SAT_W1_MASK 32'hFC000007
`define SAT_W2_MASK 32'hC000007F
`define SAT_W3_MASK 32'h007FFFFF
`define SAT_W4_MASK 32'hFFFFFFFF
`define SAT_ZERO32 32'h00000000

// ----------------------------------------------------------------
// packed static entry layout
// ----------------------------------------------------------------
`define SAT_EW 73
`define SAT_E_MAC 47:0
`define SAT_E_MACHI 47:32
`define SAT_E_MACLO 31:0
`define SAT_E_FID 54:48
`define SAT_E_FWD 61:55
`define SAT_E_USEFID 62
`define SAT_E_OVR 63
`define SAT_E_SPAN 66:64
`define SAT_E_PRI 69:67
`define SAT_E_DDROP 70
`define SAT_E_SDROP 71
`define SAT_E_VALID 72
`define SAT_E_RESET 73'h0

// ----------------------------------------------------------------
// reserved multicast
// ----------------------------------------------------------------
`define SAT_MC_PREFIX 40'h0180C20000
`define SAT_MC_LIMIT 6'h30
`define SAT_MC_TOP 7:6
`define SAT_MC_PFX 47:8
`define SAT_MC_IDX 5:0
`define SAT_MC_GRP 2:0
`define SAT_MAC_MCAST 40
`define SAT_MASK_RESET 7'h00

`endif

// ---- core/sat_match.v ----
`timescale 1ns/1ps
`default_nettype none
`include "sat_defines.vh"

module sat_match #(
  parameter ENTRIES = 16,
  parameter IDX_W = 4
) (
  input wire [ENTRIES*`SAT_EW-1:0] entries_in,
  input wire [47:0] addr_in,
  input wire [6:0] fid_in,
  output reg hit_out,
  output reg [IDX_W-1:0] idx_out
);

  integer i;
  reg [`SAT_EW-1:0] ent;

  // ----------------------------------------------------------------
  // first matching valid entry wins
  // ----------------------------------------------------------------
  always @*
  begin
    ent = `SAT_E_RESET;
    hit_out = 1'b0;
    idx_out = {IDX_W{1'b0}};
    for (i = ENTRIES - 1; i >= 0; i = i - 1)
    begin
      ent = entries_in[i*`SAT_EW +: `SAT_EW];
      if (ent[`SAT_E_VALID] && ent[`SAT_E_MAC] == addr_in &&
          !(addr_in[`SAT_MAC_MCAST] && ent[`SAT_E_USEFID] &&
            ent[`SAT_E_FID] != fid_in))
      begin
        hit_out = 1'b1;
        idx_out = i[IDX_W-1:0];
      end
    end
  end

endmodule // sat_match

`default_nettype wire

// ---- test/sat_table_access_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module sat_table_access_props (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic reg_ack_out,
  input wire logic da_valid_in,
  input wire logic dyn_hit_in,
  input wire logic sa_valid_in,
  input wire logic fwd_valid_out,
  input wire logic fwd_hit_out,
  input wire logic fwd_static_out,
  input wire logic fwd_drop_out,
  input wire logic fwd_override_out,
  input wire logic [2:0] fwd_priority_out,
  input wire logic src_valid_out,
  input wire logic src_drop_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  // ----
  // bus timing
  // ----
  property p_ack;
    (reg_wr_in || reg_rd_in) |=> reg_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_noack;
    !(reg_wr_in || reg_rd_in) ##1 1 |-> !reg_ack_out;
  endproperty
  a_noack: assert property (p_noack) else $error("stray ack");
  property p_rdz;
    !reg_ack_out |-> reg_rdata_out == 32'h00000000;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data without ack");
  // ----
  // lookup results
  // ----
  property p_fwdv;
    da_valid_in |=> fwd_valid_out;
  endproperty
  a_fwdv: assert property (p_fwdv) else $error("lookup answer missing");
  property p_fwdn;
    !da_valid_in |=> !fwd_valid_out && !fwd_hit_out;
  endproperty
  a_fwdn: assert property (p_fwdn) else $error("stray lookup answer");
  property p_dyn;
    da_valid_in && dyn_hit_in |=> fwd_hit_out;
  endproperty
  a_dyn: assert property (p_dyn) else $error("dynamic hit lost");
  property p_srcv;
    sa_valid_in |=> src_valid_out;
  endproperty
  a_srcv: assert property (p_srcv) else $error("source answer missing");
  property p_sdrop;
    src_drop_out |-> src_valid_out;
  endproperty
  a_sdrop: assert property (p_sdrop) else $error("source drop alone");
  property p_ddrop;
    fwd_drop_out |-> fwd_static_out && fwd_hit_out && fwd_valid_out;
  endproperty
  a_ddrop: assert property (p_ddrop) else $error("drop without static hit");
  property p_idle;
    !fwd_static_out |-> !fwd_override_out && fwd_priority_out == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("entry fields without hit");
  c_drop: cover property (fwd_static_out && fwd_drop_out);
  c_sdrop: cover property (src_drop_out);
  c_dyn: cover property (da_valid_in && dyn_hit_in);
endmodule // sat_table_access_props
bind sat_table_access sat_table_access_props i_props (.*);
`default_nettype wire

// ---- test/sat_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sat_defines.vh"
module sat_host_model (
  input wire logic sys_clk_in,
  input wire logic reg_ack_in,
  input wire logic [31:0] reg_rdata_in,
  output logic [15:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [31:0] reg_wdata_out
);
  initial
  begin
    reg_addr_out = 16'h0000;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 32'h00000000;
  end
  // ----
  // one register cycle, strobe one clock
  // ----
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    begin
      @(posedge sys_clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_rd_out <= rd;
      reg_wr_out <= !rd;
      @(posedge sys_clk_in);
      reg_rd_out <= 1'b0;
      reg_wr_out <= 1'b0;
      n = 0;
      do
      begin
        @(posedge sys_clk_in);
        n++;
      end
      while (reg_ack_in !== 1'b1 && n < 4);
      q = reg_rdata_in;
      if (n >= 4)
      begin
        tb.errors++;
        tb.finish_test();
      end
    end
  endtask
  // ----
  // command, then poll until done
  // ----
  task automatic cmd(input logic [31:0] c);
    logic [31:0] q;
    int n;
    begin
      xfer(1'b0, `SAT_OFF_CTRL, c, q);
      n = 0;
      do
      begin
        xfer(1'b1, `SAT_OFF_CTRL, 32'h00000000, q);
        n++;
      end
      while (q[`SAT_CTL_GO] !== 1'b0 && n < 4);
      if (n >= 4)
      begin
        tb.errors++;
        tb.finish_test();
      end
    end
  endtask
  task automatic st_write(input logic [3:0] i, input logic [31:0] w1, input logic [31:0] w2,
    input logic [31:0] w3, input logic [31:0] w4);
    logic [31:0] q;
    begin
      xfer(1'b0, `SAT_OFF_W1, w1, q);
      xfer(1'b0, `SAT_OFF_W2, w2, q);
      xfer(1'b0, `SAT_OFF_W3, w3, q);
      xfer(1'b0, `SAT_OFF_W4, w4, q);
      cmd({23'h000000, 1'b1, 1'b0, 1'b0, 2'h0, i});
    end
  endtask
  task automatic mc_write(input logic [5:0] i, input logic [31:0] m);
    logic [31:0] q;
    begin
      xfer(1'b0, `SAT_OFF_W2, m, q);
      cmd({23'h000000, 1'b1, 1'b0, 1'b1, i});
    end
  endtask
endmodule // sat_host_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sat_defines.vh"
module tb;
  typedef struct packed {
    logic [47:0] da;
    logic [6:0] filter_group_id;
    logic dh;
    logic [6:0] dm;
    logic [17:0] ex;
  } sat_row_t;
  logic sys_clk_in, resetn_in, reg_wr_in, reg_rd_in, reg_ack_out;
  logic da_valid_in, dyn_hit_in, sa_valid_in, fwd_valid_out, fwd_hit_out, fwd_static_out;
  logic fwd_drop_out, src_valid_out, src_drop_out, fwd_override_out;
  logic [6:0] da_fid_in;
  logic [2:0] fwd_span_out;
  logic [15:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, q;
  logic [47:0] da_in, sa_in;
  logic [6:0] dyn_mask_in, fwd_mask_out;
  logic [2:0] fwd_priority_out;
  logic [31:0] ew [4];
  sat_row_t rows [8];
  int errors, num_checks;
  sat_table_access i_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
    .da_valid_in(da_valid_in), .da_in(da_in), .da_fid_in(da_fid_in), .dyn_hit_in(dyn_hit_in),
    .dyn_mask_in(dyn_mask_in), .sa_valid_in(sa_valid_in), .sa_in(sa_in), .sa_fid_in(7'h00),
    .fwd_valid_out(fwd_valid_out), .fwd_hit_out(fwd_hit_out),
    .fwd_static_out(fwd_static_out), .fwd_mask_out(fwd_mask_out),
    .fwd_drop_out(fwd_drop_out), .fwd_override_out(fwd_override_out),
    .fwd_priority_out(fwd_priority_out), .fwd_span_out(fwd_span_out),
    .src_valid_out(src_valid_out), .src_drop_out(src_drop_out));
  sat_host_model i_host (.sys_clk_in(sys_clk_in), .reg_ack_in(reg_ack_out),
    .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      num_checks++;
      if (g !== e)
      begin
        errors++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task automatic finish_test;
    begin
      if (errors == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    errors = 0;
    num_checks = 0;
    {resetn_in, da_valid_in, dyn_hit_in, sa_valid_in} = 4'h0;
    {da_in, sa_in, dyn_mask_in} = 103'h0;
    da_fid_in = 7'h00;
    rows[0] = '{48'h0A0B0C0D0E0F, 7'h00, 1'b1, 7'h01, {3'h7, 7'h15, 1'b0, 3'h5, 1'b1, 3'h3}};
    rows[1] = '{48'h112233445566, 7'h00, 1'b0, 7'h00, {3'h7, 7'h7F, 1'b1, 3'h0, 1'b0, 3'h0}};
    rows[2] = '{48'h020000000001, 7'h00, 1'b1, 7'h0C, {3'h6, 7'h0C, 1'b0, 3'h0, 1'b0, 3'h0}};
    rows[3] = '{48'h020000000002, 7'h00, 1'b0, 7'h00, {3'h4, 7'h00, 1'b0, 3'h0, 1'b0, 3'h0}};
    rows[4] = '{48'h0180C200000B, 7'h00, 1'b1, 7'h01, {3'h7, 7'h22, 1'b0, 3'h0, 1'b0, 3'h0}};
    rows[5] = '{48'h0180C2000030, 7'h00, 1'b0, 7'h00, {3'h4, 7'h00, 1'b0, 3'h0, 1'b0, 3'h0}};
    rows[6] = '{48'h030000000001, 7'h05, 1'b0, 7'h00, {3'h7, 7'h01, 1'b0, 3'h0, 1'b0, 3'h0}};
    rows[7] = '{48'h030000000001, 7'h06, 1'b1, 7'h08, {3'h6, 7'h08, 1'b0, 3'h0, 1'b0, 3'h0}};
    ew = '{32'h94000003, 32'h80000015, 32'h00000A0B, 32'h0C0D0E0F};
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    i_host.xfer(1'b1, `SAT_OFF_W4, 32'h00000000, q);
    chk("w4 reset", 32'h00000000, q);
    i_host.st_write(4'h0, 32'h97FFFFFB, 32'hBFFFFF95, 32'hFF800A0B, 32'h0C0D0E0F);
    i_host.st_write(4'hF, 32'hE0000000, 32'h0000007F, 32'h00001122, 32'h33445566);
    i_host.st_write(4'h1, 32'h80000000, 32'h40000001, 32'h00050300, 32'h00000001);
    i_host.mc_write(6'h03, 32'h00000022);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk_in);
      da_valid_in <= 1'b1;
      da_in <= rows[i].da;
      da_fid_in <= rows[i].filter_group_id;
      dyn_hit_in <= rows[i].dh;
      dyn_mask_in <= rows[i].dm;
      @(posedge sys_clk_in);
      da_valid_in <= 1'b0;
      #1;
      chk("lookup", {14'h0, rows[i].ex},
        {14'h0, fwd_valid_out, fwd_hit_out, fwd_static_out, fwd_mask_out, fwd_drop_out,
        fwd_priority_out, fwd_override_out, fwd_span_out});
    end
    // ----
    // read back, masked reserved bits
    // ----
    i_host.cmd(32'h00000180);
    i_host.xfer(1'b1, `SAT_OFF_CTRL, 32'h00000000, q);
    chk("go bit", 32'h00000000, {31'h0, q[`SAT_CTL_GO]});
    for (int k = 0; k < 4; k++)
    begin
      i_host.xfer(1'b1, 16'(`SAT_OFF_W1 + 4 * k), 32'h00000000, q);
      chk("window", ew[k], q);
    end
    i_host.cmd(32'h000001CB);
    i_host.xfer(1'b1, `SAT_OFF_W2, 32'h00000000, q);
    chk("mcast group", 32'h80000022, q);
    i_host.cmd(32'h000001F0);
    i_host.xfer(1'b1, `SAT_OFF_W2, 32'h00000000, q);
    chk("mcast top", 32'h80000000, q);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk_in);
      sa_valid_in <= 1'b1;
      sa_in <= k == 0 ? 48'h112233445566 : 48'h0A0B0C0D0E0F;
      @(posedge sys_clk_in);
      sa_valid_in <= 1'b0;
      #1;
      chk("source", {30'h0, 1'b1, k == 0}, {30'h0, src_valid_out, src_drop_out});
    end
    // ----
    // reset in mid-run clears window and table
    // ----
    @(posedge sys_clk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    i_host.xfer(1'b1, `SAT_OFF_W2, 32'h00000000, q);
    chk("w2 reset", 32'h00000000, q);
    i_host.cmd(32'h00000180);
    i_host.xfer(1'b1, `SAT_OFF_W1, 32'h00000000, q);
    chk("entry reset", 32'h00000000, q);
    i_host.xfer(1'b1, 16'h0500, 32'h00000000, q);
    chk("unmapped", 32'h00000000, q);
    finish_test();
  end
endmodule // tb
`default_nettype wire
